// ===== rtl/steb_pkg.sv
// Package: widths, register selectors and reset values for the status bank
package steb_pkg;
  localparam int DATA_W = 16;
  localparam int SEL_W = 4;
  // Register selectors used by the command port
  localparam logic [3:0] SEL_OPER_EVENT = 4'h0;
  localparam logic [3:0] SEL_OPER_COND = 4'h1;
  localparam logic [3:0] SEL_OPER_ENAB = 4'h2;
  localparam logic [3:0] SEL_OPER_FALL = 4'h3;
  localparam logic [3:0] SEL_OPER_RISE = 4'h4;
  localparam logic [3:0] SEL_QUES_EVENT = 4'h5;
  localparam logic [3:0] SEL_QUES_COND = 4'h6;
  localparam logic [3:0] SEL_QUES_ENAB = 4'h7;
  localparam logic [3:0] SEL_QUES_FALL = 4'h8;
  localparam logic [3:0] SEL_QUES_RISE = 4'h9;
  // Reset and preset values
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] PRESET_RISE = 16'hFFFF;
  localparam logic [15:0] PRESET_FALL = 16'h0000;
  localparam logic [15:0] PRESET_ENAB = 16'h0000;
  localparam logic [15:0] EVENT_RESET = 16'h0000;
  localparam logic [15:0] COND_RESET = 16'h0000;
endpackage

// ===== rtl/steb_edge_filter.sv
// Transition filter: flags condition edges allowed by the polarity masks
`timescale 1ns/1ns
module steb_edge_filter #(
  parameter int WIDTH = 16
) (
  // Condition now and one cycle before
  input wire logic [WIDTH-1:0] cond_in,
  input wire logic [WIDTH-1:0] cond_prev_in,
  // Polarity masks
  input wire logic [WIDTH-1:0] rise_mask_in,
  input wire logic [WIDTH-1:0] fall_mask_in,
  // Bits to latch into the event register
  output logic [WIDTH-1:0] hit_out
);
  generate
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        hit_out[i] = (rise_mask_in[i] & cond_in[i] & ~cond_prev_in[i])
                   | (fall_mask_in[i] & ~cond_in[i] & cond_prev_in[i]);
      end
    end
  endgenerate
endmodule

// ===== rtl/steb_group.sv
// One status group: condition, masks, sticky event register and summary
`timescale 1ns/1ns
module steb_group #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Live condition sources
  input wire logic [WIDTH-1:0] cond_src_in,
  // Actions
  input wire logic preset_in,
  input wire logic clear_status_in,
  input wire logic event_read_in,
  // Mask writes
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic wr_enab_in,
  input wire logic wr_fall_in,
  input wire logic wr_rise_in,
  // Register contents
  output logic [WIDTH-1:0] cond_out,
  output logic [WIDTH-1:0] event_out,
  output logic [WIDTH-1:0] enab_out,
  output logic [WIDTH-1:0] fall_out,
  output logic [WIDTH-1:0] rise_out,
  output logic summary_out
);
  logic [WIDTH-1:0] cond_prev, next_cond;
  logic [WIDTH-1:0] next_event, next_enab, next_fall, next_rise;
  logic [WIDTH-1:0] hit;

  steb_edge_filter #(.WIDTH(WIDTH)) u_filter (
    .cond_in(cond_out),
    .cond_prev_in(cond_prev),
    .rise_mask_in(rise_out),
    .fall_mask_in(fall_out),
    .hit_out(hit)
  );

  always_comb begin
    next_cond = cond_src_in;
    next_enab = enab_out;
    next_fall = fall_out;
    next_rise = rise_out;
    if (wr_enab_in) begin
      next_enab = wdata_in;
    end
    if (wr_fall_in) begin
      next_fall = wdata_in;
    end
    if (wr_rise_in) begin
      next_rise = wdata_in;
    end
    if (preset_in) begin
      // Only the masks of this group move; nothing else is touched
      next_rise = WIDTH'(steb_pkg::PRESET_RISE);
      next_fall = WIDTH'(steb_pkg::PRESET_FALL);
      next_enab = WIDTH'(steb_pkg::PRESET_ENAB);
    end
    // Read clear and clear status lose against a new edge
    next_event = event_out;
    if (event_read_in || clear_status_in) begin
      next_event = '0;
    end
    next_event = next_event | hit;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      // Condition cleared to zero; persisting sources reappear on the first cycle after reset
      cond_out <= '0;
      cond_prev <= '0;
      event_out <= '0;
      enab_out <= '0;
      fall_out <= '0;
      rise_out <= '0;
    end else begin
      cond_out <= next_cond;
      cond_prev <= cond_out;
      event_out <= next_event;
      enab_out <= next_enab;
      fall_out <= next_fall;
      rise_out <= next_rise;
    end
  end

  assign summary_out = |(event_out & enab_out);
endmodule

// ===== rtl/steb_bank.sv
// Top: status transition event bank with two groups and a command port
`timescale 1ns/1ns
module steb_bank #(
  parameter int WIDTH = steb_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Condition sources
  input wire logic [WIDTH-1:0] oper_cond_src_in,
  input wire logic [WIDTH-1:0] ques_cond_src_in,
  // Actions, one-cycle pulses
  input wire logic preset_in,
  input wire logic clear_status_in,
  input wire logic inst_reset_in,
  // Command port
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [steb_pkg::SEL_W-1:0] req_sel_in,
  input wire logic [WIDTH-1:0] req_wdata_in,
  // Answer
  output logic ack_out,
  output logic [WIDTH-1:0] rdata_out,
  // Summary bits
  output logic oper_summary_out,
  output logic ques_summary_out
);
  if (WIDTH != steb_pkg::DATA_W) begin : g_width_check
    $error("steb_bank supports only 16-bit registers");
  end

  logic rd, wr;
  logic [WIDTH-1:0] o_cond, o_evt, o_enab, o_fall, o_rise;
  logic [WIDTH-1:0] q_cond, q_evt, q_enab, q_fall, q_rise;
  logic [WIDTH-1:0] next_rdata;
  logic next_ack;

  function automatic logic sel_is(input logic [3:0] s, input logic [3:0] v);
    sel_is = (s == v);
  endfunction

  assign rd = req_in & ~req_write_in;
  assign wr = req_in & req_write_in;

  // ==========================================================
  // Groups; instrument reset is not connected to them
  steb_group #(.WIDTH(WIDTH)) u_oper (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .cond_src_in(oper_cond_src_in),
    .preset_in(preset_in),
    .clear_status_in(clear_status_in),
    .event_read_in(rd & sel_is(req_sel_in, steb_pkg::SEL_OPER_EVENT)),
    .wdata_in(req_wdata_in),
    .wr_enab_in(wr & sel_is(req_sel_in, steb_pkg::SEL_OPER_ENAB)),
    .wr_fall_in(wr & sel_is(req_sel_in, steb_pkg::SEL_OPER_FALL)),
    .wr_rise_in(wr & sel_is(req_sel_in, steb_pkg::SEL_OPER_RISE)),
    .cond_out(o_cond),
    .event_out(o_evt),
    .enab_out(o_enab),
    .fall_out(o_fall),
    .rise_out(o_rise),
    .summary_out(oper_summary_out)
  );

  steb_group #(.WIDTH(WIDTH)) u_ques (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .cond_src_in(ques_cond_src_in),
    .preset_in(preset_in),
    .clear_status_in(clear_status_in),
    .event_read_in(rd & sel_is(req_sel_in, steb_pkg::SEL_QUES_EVENT)),
    .wdata_in(req_wdata_in),
    .wr_enab_in(wr & sel_is(req_sel_in, steb_pkg::SEL_QUES_ENAB)),
    .wr_fall_in(wr & sel_is(req_sel_in, steb_pkg::SEL_QUES_FALL)),
    .wr_rise_in(wr & sel_is(req_sel_in, steb_pkg::SEL_QUES_RISE)),
    .cond_out(q_cond),
    .event_out(q_evt),
    .enab_out(q_enab),
    .fall_out(q_fall),
    .rise_out(q_rise),
    .summary_out(ques_summary_out)
  );

  // ==========================================================
  // Read mux; event contents captured before the clear lands
  always_comb begin
    next_ack = req_in;
    next_rdata = rdata_out;
    if (rd) begin
      case (req_sel_in)
        steb_pkg::SEL_OPER_EVENT: next_rdata = o_evt;
        steb_pkg::SEL_OPER_COND: next_rdata = o_cond;
        steb_pkg::SEL_OPER_ENAB: next_rdata = o_enab;
        steb_pkg::SEL_OPER_FALL: next_rdata = o_fall;
        steb_pkg::SEL_OPER_RISE: next_rdata = o_rise;
        steb_pkg::SEL_QUES_EVENT: next_rdata = q_evt;
        steb_pkg::SEL_QUES_COND: next_rdata = q_cond;
        steb_pkg::SEL_QUES_ENAB: next_rdata = q_enab;
        steb_pkg::SEL_QUES_FALL: next_rdata = q_fall;
        steb_pkg::SEL_QUES_RISE: next_rdata = q_rise;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ack_out <= 1'b0;
      rdata_out <= '0;
    end else begin
      ack_out <= next_ack;
      rdata_out <= next_rdata;
    end
  end

  // Instrument reset has no effect on stored state here: conditions
  // track their sources every cycle anyway, events are kept
  logic unused_inst_reset;
  assign unused_inst_reset = inst_reset_in;
endmodule

// ===== bench/steb_bank_props.sv
// Checker: port-level assertions for the status bank
`timescale 1ns/1ns
module steb_bank_props #(
  parameter int WIDTH = 16
) (
  // Clock, reset, sources and actions
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] oper_cond_src_in,
  input wire logic [WIDTH-1:0] ques_cond_src_in,
  input wire logic preset_in,
  // Command port and answers
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [3:0] req_sel_in,
  input wire logic ack_out,
  input wire logic [WIDTH-1:0] rdata_out,
  input wire logic oper_summary_out,
  input wire logic ques_summary_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  wire rd_req = req_in && !req_write_in;
  chk_ack_after_req: assert property (req_in |=> ack_out)
    else $error("ack missing after request");
  chk_ack_cause: assert property (ack_out |-> $past(req_in))
    else $error("ack without request");
  chk_preset_quiet: assert property (preset_in |=>
    !oper_summary_out && !ques_summary_out)
    else $error("summary set after preset");
  chk_oper_cond: assert property (rd_req && !$past(srst_in) &&
    req_sel_in == steb_pkg::SEL_OPER_COND
    |=> rdata_out == $past(oper_cond_src_in, 2))
    else $error("operation condition read wrong");
  chk_ques_cond: assert property (rd_req && !$past(srst_in) &&
    req_sel_in == steb_pkg::SEL_QUES_COND
    |=> rdata_out == $past(ques_cond_src_in, 2))
    else $error("questionable condition read wrong");
  chk_bad_sel: assert property (rd_req &&
    req_sel_in > steb_pkg::SEL_QUES_RISE |=> rdata_out == 16'h0000)
    else $error("unknown selector read not zero");
  chk_rdata_hold: assert property (!rd_req |=> $stable(rdata_out))
    else $error("read data moved without read");
  chk_reset_clear: assert property (disable iff (1'b0) srst_in |=>
    !ack_out && rdata_out == 16'h0000 && !oper_summary_out)
    else $error("outputs not cleared by reset");
  cover property (oper_summary_out);
  cover property (ques_summary_out);
  cover property (preset_in);
endmodule
bind steb_bank steb_bank_props #(.WIDTH(WIDTH)) steb_bank_props_inst (
  .clk_sys_in(clk_sys_in), .srst_in(srst_in),
  .oper_cond_src_in(oper_cond_src_in), .ques_cond_src_in(ques_cond_src_in),
  .preset_in(preset_in), .req_in(req_in), .req_write_in(req_write_in),
  .req_sel_in(req_sel_in), .ack_out(ack_out), .rdata_out(rdata_out),
  .oper_summary_out(oper_summary_out), .ques_summary_out(ques_summary_out));

// ===== bench/steb_host_model.sv
// Host model: issues one status command per call
`timescale 1ns/1ns
module steb_host_model (
  // Clock and answer
  input wire logic clk_sys_in,
  input wire logic ack_in,
  input wire logic [15:0] rdata_in,
  // Command
  output logic req_out = 1'b0,
  output logic req_write_out = 1'b0,
  output logic [3:0] req_sel_out = 4'h0,
  output logic [15:0] req_wdata_out = 16'h0000
);
  task automatic xfer(input logic w, input logic [3:0] s,
    input logic [15:0] d, output logic a, output logic [15:0] q);
    @(posedge clk_sys_in);
    #1;
    req_out = 1'b1;
    req_write_out = w;
    req_sel_out = s;
    req_wdata_out = d;
    @(posedge clk_sys_in);
    #1;
    req_out = 1'b0;
    req_wdata_out = ~d;
    a = ack_in;
    q = rdata_in;
  endtask
endmodule

// ===== bench/test_steb_bank.sv
// Testbench: status bank command sequences with expected values
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module test_steb_bank;
  logic clk_sys_in = 0, srst_in = 1, preset = 0, clr = 0, irst = 0;
  logic req, req_write, ack;
  logic [3:0] sel;
  logic [15:0] wdata, rdata;
  logic [15:0] src [2] = '{16'h0000, 16'h0000};
  logic sum [2];
  logic [3:0] msk [6] = '{4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
  int fails = 0, num_checks = 0;
  initial forever #4 clk_sys_in = ~clk_sys_in;
  steb_bank steb_bank_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .oper_cond_src_in(src[0]), .ques_cond_src_in(src[1]),
    .preset_in(preset), .clear_status_in(clr), .inst_reset_in(irst),
    .req_in(req), .req_write_in(req_write), .req_sel_in(sel),
    .req_wdata_in(wdata), .ack_out(ack), .rdata_out(rdata),
    .oper_summary_out(sum[0]), .ques_summary_out(sum[1]));
  steb_host_model steb_host_model_inst (.clk_sys_in(clk_sys_in),
    .ack_in(ack), .rdata_in(rdata), .req_out(req), .req_write_out(req_write),
    .req_sel_out(sel), .req_wdata_out(wdata));
  task automatic rd(input logic [3:0] s, input logic [15:0] e);
    logic a;
    logic [15:0] q;
    steb_host_model_inst.xfer(1'b0, s, 16'h0000, a, q);
    `CHK(a, 1'b1)
    `CHK(q, e)
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    logic a;
    logic [15:0] q;
    steb_host_model_inst.xfer(1'b1, s, d, a, q);
    `CHK(a, 1'b1)
  endtask
  task automatic pulse(ref logic p);
    @(posedge clk_sys_in);
    #1 p = 1'b1;
    @(posedge clk_sys_in);
    #1 p = 1'b0;
  endtask
  task automatic grp(input int g);
    logic [3:0] b;
    b = g ? 4'h5 : 4'h0;
    wr(b + 4'h2, 16'h0004);
    wr(b + 4'h3, 16'h0006);
    wr(b + 4'h4, 16'h0005);
    rd(b + 4'h3, 16'h0006);
    src[g] = 16'h000F;
    repeat (2) @(posedge clk_sys_in);
    rd(b + 4'h1, 16'h000F);
    `CHK(sum[g], 1'b1)
    rd(b, 16'h0005);
    `CHK(sum[g], 1'b0)
    src[g] = 16'h0000;
    repeat (3) @(posedge clk_sys_in);
    #1 src[g] = 16'h000F;
    pulse(irst);
    rd(b + 4'h1, 16'h000F);
    pulse(preset);
    `CHK(sum[g], 1'b0)
    rd(b, 16'h0007);
    rd(b, 16'h0000);
    rd(b + 4'h2, 16'h0000);
    rd(b + 4'h3, 16'h0000);
    rd(b + 4'h4, 16'hFFFF);
    wr(b + 4'h2, 16'h8000);
    src[g] = 16'h800F;
    rd(b + 4'h2, 16'h8000);
    `CHK(sum[g], 1'b1)
    pulse(clr);
    `CHK(sum[g], 1'b0)
    rd(b + 4'h2, 16'h8000);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_in);
    #1 srst_in = 1'b0;
    for (int i = 0; i < 6; i++) rd(msk[i], 16'h0000);
    for (int i = 0; i < 6; i++) wr(msk[i], {12'hA50, msk[i]});
    for (int i = 0; i < 6; i++) rd(msk[i], {12'hA50, msk[i]});
    wr(4'h1, 16'hFFFF);
    rd(4'h1, 16'h0000);
    rd(4'hF, 16'h0000);
    grp(0);
    grp(1);
    final_report();
  end
  initial begin
    #200000;
    fails++;
    final_report();
  end
endmodule
